// *** common/ephy_defines.vh ***
// Constants for the Ethernet PHY status, LED and interrupt block.
// Assumes a 32-bit APB slave with byte addresses and one register per word.
`ifndef EPHY_DEFINES_VH
`define EPHY_DEFINES_VH

// Register byte addresses
`define EPHY_ADDR_W 8
`define EPHY_A_PHY_STATUS_TWO 8'h00
`define EPHY_A_PHY_LED_CONTROL 8'h04
`define EPHY_A_IRQ_ENABLE 8'h08
`define EPHY_A_IRQ_FLAGS 8'h0C
`define EPHY_A_PHY_IRQ_ENABLE 8'h10
`define EPHY_A_PHY_IRQ_REQUEST 8'h14
`define EPHY_A_GLOBAL_ENABLE 8'h18

// Reset values
`define EPHY_LED_CTRL_RST 16'h3422
`define EPHY_IRQ_EN_RST 8'h00

// Status register positions
`define EPHY_ST_TX 13
`define EPHY_ST_RX 12
`define EPHY_ST_COL 11
`define EPHY_ST_LINK 10

// LED control fields
`define EPHY_LED_A_HI 11
`define EPHY_LED_A_LO 8
`define EPHY_LED_B_HI 7
`define EPHY_LED_B_LO 4
`define EPHY_STR_HI 3
`define EPHY_STR_LO 2
`define EPHY_STR_EN 1

// Interrupt enable / flag positions
`define EPHY_IRQ_PKT 6
`define EPHY_IRQ_DMA 5
`define EPHY_IRQ_LINK 4
`define EPHY_IRQ_TX 3
`define EPHY_IRQ_TXER 1
`define EPHY_IRQ_RXER 0
`define EPHY_IRQ_EN_MASK 8'h7B
`define EPHY_IRQ_W1C_MASK 8'h2B
`define EPHY_IRQ_FLAG_MASK 8'h6B

// PHY-level interrupt register positions
`define EPHY_PIRQ_LINK 4
`define EPHY_PIRQ_GLOBAL 2
`define EPHY_PIRQ_GEN 1

// LED selector codes
`define EPHY_SEL_TX 4'h1
`define EPHY_SEL_RX 4'h2
`define EPHY_SEL_COL 4'h3
`define EPHY_SEL_LINK 4'h4
`define EPHY_SEL_DPX 4'h5
`define EPHY_SEL_TXRX 4'h7
`define EPHY_SEL_ON 4'h8
`define EPHY_SEL_OFF 4'h9
`define EPHY_SEL_FAST 4'hA
`define EPHY_SEL_SLOW 4'hB
`define EPHY_SEL_LINK_RX 4'hC
`define EPHY_SEL_LINK_TXRX 4'hD

// Stretch time codes
`define EPHY_STR_NORMAL 2'h0
`define EPHY_STR_MEDIUM 2'h1
`define EPHY_STR_LONG 2'h2
`define EPHY_STR_RSVD 2'h3

// Timing in module clock cycles
`define EPHY_CNT_W 24
`define EPHY_NORMAL_STRETCH_CYC 24'h0F_4240
`define EPHY_MEDIUM_STRETCH_CYC 24'h1E_8480
`define EPHY_LONG_STRETCH_CYC 24'h3D_0900
`define EPHY_FAST_BLINK_CYC 24'h1E_8480
`define EPHY_SLOW_BLINK_CYC 24'h7A_1200

`endif

// *** verilog/ephy_status_led.v ***
// Ethernet PHY status register, two LED drivers and interrupt gathering.
// Assumes an APB3 master on ref_clk; PHY status pins are asynchronous,
// event pulses come from logic on ref_clk.
//
// Implementation choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "ephy_defines.vh"
`default_nettype none

module ephy_led_drv #(
  parameter CNT_W = `EPHY_CNT_W,
  parameter [CNT_W-1:0] NORMAL_CYC = `EPHY_NORMAL_STRETCH_CYC,
  parameter [CNT_W-1:0] MEDIUM_CYC = `EPHY_MEDIUM_STRETCH_CYC,
  parameter [CNT_W-1:0] LONG_CYC = `EPHY_LONG_STRETCH_CYC
) (
  // Clock and reset
  input wire ref_clk,
  input wire sys_rst,
  // Configuration
  input wire [3:0] selCode,
  input wire [1:0] stretchTimeSelect,
  input wire pulseStretchEnable,
  // Conditions
  input wire txAct,
  input wire rxAct,
  input wire colAct,
  input wire linkUp,
  input wire fullDuplex,
  input wire blinkFast,
  input wire blinkSlow,
  // Pin drive
  output reg ledOut_ff
);
  reg [CNT_W-1:0] stretchCnt_ff;
  reg [CNT_W-1:0] nxt_stretchCnt;
  reg [CNT_W-1:0] duration;
  reg actEvt;
  reg nxt_ledOut;
  wire strTimeOk;
  wire stretched;

  assign strTimeOk = (stretchTimeSelect != `EPHY_STR_RSVD);
  assign stretched = actEvt | (stretchCnt_ff != {CNT_W{1'b0}});

  always @* begin
    case (stretchTimeSelect)
      `EPHY_STR_NORMAL: duration = NORMAL_CYC;
      `EPHY_STR_MEDIUM: duration = MEDIUM_CYC;
      `EPHY_STR_LONG: duration = LONG_CYC;
      default: duration = {CNT_W{1'b0}};
    endcase
  end

  always @* begin
    case (selCode)
      `EPHY_SEL_TX: actEvt = txAct;
      `EPHY_SEL_RX: actEvt = rxAct;
      `EPHY_SEL_COL: actEvt = colAct;
      `EPHY_SEL_TXRX: actEvt = txAct | rxAct;
      `EPHY_SEL_LINK_RX: actEvt = rxAct;
      `EPHY_SEL_LINK_TXRX: actEvt = txAct | rxAct;
      default: actEvt = 1'b0;
    endcase
  end

  // Counter reloads while the event lasts and runs down afterwards
  always @* begin
    if (actEvt) begin
      nxt_stretchCnt = duration;
    end else if (stretchCnt_ff != {CNT_W{1'b0}}) begin
      nxt_stretchCnt = stretchCnt_ff - {{(CNT_W-1){1'b0}}, 1'b1};
    end else begin
      nxt_stretchCnt = stretchCnt_ff;
    end
  end

  always @* begin
    case (selCode)
      `EPHY_SEL_TX, `EPHY_SEL_RX, `EPHY_SEL_COL, `EPHY_SEL_TXRX: begin
        if (pulseStretchEnable) begin
          nxt_ledOut = strTimeOk & stretched;
        end else begin
          nxt_ledOut = actEvt;
        end
      end
      `EPHY_SEL_LINK: nxt_ledOut = linkUp;
      `EPHY_SEL_DPX: nxt_ledOut = fullDuplex;
      `EPHY_SEL_ON: nxt_ledOut = 1'b1;
      `EPHY_SEL_OFF: nxt_ledOut = 1'b0;
      `EPHY_SEL_FAST: nxt_ledOut = blinkFast;
      `EPHY_SEL_SLOW: nxt_ledOut = blinkSlow;
      // Lit with link, dark while stretched activity lasts
      `EPHY_SEL_LINK_RX, `EPHY_SEL_LINK_TXRX: nxt_ledOut = linkUp & ~(strTimeOk & stretched);
      default: nxt_ledOut = 1'b0;
    endcase
  end

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      stretchCnt_ff <= {CNT_W{1'b0}};
      ledOut_ff <= 1'b0;
    end else begin
      stretchCnt_ff <= nxt_stretchCnt;
      ledOut_ff <= nxt_ledOut;
    end
  end
endmodule // ephy_led_drv

module ephy_status_led #(
  parameter CNT_W = `EPHY_CNT_W,
  parameter [CNT_W-1:0] NORMAL_STRETCH_CYC = `EPHY_NORMAL_STRETCH_CYC,
  parameter [CNT_W-1:0] MEDIUM_STRETCH_CYC = `EPHY_MEDIUM_STRETCH_CYC,
  parameter [CNT_W-1:0] LONG_STRETCH_CYC = `EPHY_LONG_STRETCH_CYC,
  parameter [CNT_W-1:0] FAST_BLINK_CYC = `EPHY_FAST_BLINK_CYC,
  parameter [CNT_W-1:0] SLOW_BLINK_CYC = `EPHY_SLOW_BLINK_CYC
) (
  // Clock and reset
  input wire ref_clk,
  input wire sys_rst,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`EPHY_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // PHY status pins, asynchronous
  input wire phySending,
  input wire phyReceiving,
  input wire phyLinkUp,
  input wire phyFullDuplex,
  // Event sources on ref_clk
  input wire rxPacketPending,
  input wire copyDone,
  input wire sendDone,
  input wire sendError,
  input wire receiveError,
  // Outputs
  output wire ledOutFirst,
  output wire ledOutSecond,
  output reg masterModuleIrqFlag
);
  reg [3:0] pinSyncA_ff;
  reg [3:0] pinSyncB_ff;
  reg linkPrev_ff;
  reg [15:0] phyLedControl_ff;
  reg [7:0] ethIrqEnable_ff;
  reg [7:0] ethIrqFlags_ff;
  reg moduleIrqGlobalEnable_ff;
  reg phyLinkIrqEn_ff;
  reg phyGlobalIrqEn_ff;
  reg phyLinkChangeFlag_ff;
  reg phyGlobalFlag_ff;
  reg [CNT_W-1:0] fastCnt_ff;
  reg [CNT_W-1:0] slowCnt_ff;
  reg blinkFast_ff;
  reg blinkSlow_ff;
  reg [31:0] rdMux;
  reg rdHit;
  reg [7:0] nxt_flags;
  wire txAct;
  wire rxAct;
  wire linkUp;
  wire fullDuplex;
  wire colAct;
  wire linkChange;
  wire xferDone;
  wire wrDone;
  wire rdTake;
  wire [15:0] phyStatusTwo;
  wire [7:0] flagView;
  wire [CNT_W-1:0] cntOne;

  assign cntOne = {{(CNT_W-1){1'b0}}, 1'b1};

  // Two-stage synchronisers for the PHY pins
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      pinSyncA_ff <= 4'h0;
      pinSyncB_ff <= 4'h0;
      linkPrev_ff <= 1'b0;
    end else begin
      pinSyncA_ff <= {phyFullDuplex, phyLinkUp, phyReceiving, phySending};
      pinSyncB_ff <= pinSyncA_ff;
      linkPrev_ff <= pinSyncB_ff[2];
    end
  end

  assign txAct = pinSyncB_ff[0];
  assign rxAct = pinSyncB_ff[1];
  assign linkUp = pinSyncB_ff[2];
  assign fullDuplex = pinSyncB_ff[3];
  assign colAct = txAct & rxAct & ~fullDuplex;
  assign linkChange = linkUp ^ linkPrev_ff;

  assign phyStatusTwo = {2'h0, txAct, rxAct, colAct, linkUp, 10'h000};

  // APB: completes in the first access cycle; pready is registered
  assign xferDone = psel & penable & pready;
  assign wrDone = xferDone & pwrite;
  // Read clears on the capture edge, so a change landing in between is not lost
  assign rdTake = psel & ~penable & ~pwrite;

  always @* begin
    rdHit = 1'b1;
    case (paddr)
      `EPHY_A_PHY_STATUS_TWO: rdMux = {16'h0000, phyStatusTwo};
      `EPHY_A_PHY_LED_CONTROL: rdMux = {16'h0000, phyLedControl_ff};
      `EPHY_A_IRQ_ENABLE: rdMux = {24'h00_0000, ethIrqEnable_ff};
      `EPHY_A_IRQ_FLAGS: rdMux = {24'h00_0000, flagView};
      `EPHY_A_PHY_IRQ_ENABLE: rdMux = {27'h000_0000, phyLinkIrqEn_ff, 2'h0, phyGlobalIrqEn_ff, 1'b0};
      `EPHY_A_PHY_IRQ_REQUEST: rdMux = {27'h000_0000, phyLinkChangeFlag_ff, 1'b0, phyGlobalFlag_ff, 2'h0};
      `EPHY_A_GLOBAL_ENABLE: rdMux = {31'h0000_0000, moduleIrqGlobalEnable_ff};
      default: begin
        rdMux = 32'h0000_0000;
        rdHit = 1'b0;
      end
    endcase
  end

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (psel & ~penable) begin
      prdata <= pwrite ? 32'h0000_0000 : rdMux;
      pready <= 1'b1;
      pslverr <= ~rdHit;
    end else begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Software-written configuration
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      phyLedControl_ff <= `EPHY_LED_CTRL_RST;
      ethIrqEnable_ff <= `EPHY_IRQ_EN_RST;
      moduleIrqGlobalEnable_ff <= 1'b0;
      phyLinkIrqEn_ff <= 1'b0;
      phyGlobalIrqEn_ff <= 1'b0;
    end else if (wrDone) begin
      case (paddr)
        // LED control reserved bits kept as written; the enable registers store only their defined bits
        `EPHY_A_PHY_LED_CONTROL: phyLedControl_ff <= pwdata[15:0];
        `EPHY_A_IRQ_ENABLE: ethIrqEnable_ff <= pwdata[7:0] & `EPHY_IRQ_EN_MASK;
        `EPHY_A_GLOBAL_ENABLE: moduleIrqGlobalEnable_ff <= pwdata[0];
        `EPHY_A_PHY_IRQ_ENABLE: begin
          phyLinkIrqEn_ff <= pwdata[`EPHY_PIRQ_LINK];
          phyGlobalIrqEn_ff <= pwdata[`EPHY_PIRQ_GEN];
        end
        default: ethIrqEnable_ff <= ethIrqEnable_ff;
      endcase
    end
  end

  // PHY-level flags: set wins over the clear by a read
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      phyLinkChangeFlag_ff <= 1'b0;
      phyGlobalFlag_ff <= 1'b0;
    end else begin
      if (linkChange) begin
        phyLinkChangeFlag_ff <= 1'b1;
      end else if (rdTake && paddr == `EPHY_A_PHY_IRQ_REQUEST) begin
        phyLinkChangeFlag_ff <= 1'b0;
      end
      if (linkChange & phyLinkIrqEn_ff & phyGlobalIrqEn_ff) begin
        phyGlobalFlag_ff <= 1'b1;
      end else if (rdTake && paddr == `EPHY_A_PHY_IRQ_REQUEST) begin
        phyGlobalFlag_ff <= 1'b0;
      end
    end
  end

  // Module flags set on events regardless of enables; write one clears all but the packet bit, which follows rxPacketPending
  always @* begin
    nxt_flags = ethIrqFlags_ff;
    if (wrDone && paddr == `EPHY_A_IRQ_FLAGS) begin
      nxt_flags = ethIrqFlags_ff & ~(pwdata[7:0] & `EPHY_IRQ_W1C_MASK);
    end
    nxt_flags[`EPHY_IRQ_PKT] = rxPacketPending;
    if (copyDone) begin
      nxt_flags[`EPHY_IRQ_DMA] = 1'b1;
    end
    if (sendDone) begin
      nxt_flags[`EPHY_IRQ_TX] = 1'b1;
    end
    if (sendError) begin
      nxt_flags[`EPHY_IRQ_TXER] = 1'b1;
    end
    if (receiveError) begin
      nxt_flags[`EPHY_IRQ_RXER] = 1'b1;
    end
    nxt_flags = nxt_flags & `EPHY_IRQ_FLAG_MASK; // Link bit comes from the PHY flag
  end

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      ethIrqFlags_ff <= 8'h00;
    end else begin
      ethIrqFlags_ff <= nxt_flags;
    end
  end

  // Link change flag only rises through the enabled PHY global flag
  assign flagView = ethIrqFlags_ff | ({7'h00, phyGlobalFlag_ff} << `EPHY_IRQ_LINK);

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      masterModuleIrqFlag <= 1'b0;
    end else begin
      masterModuleIrqFlag <= moduleIrqGlobalEnable_ff & (|(flagView & ethIrqEnable_ff));
    end
  end

  // Blink sources: half periods in clock cycles
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      fastCnt_ff <= {CNT_W{1'b0}};
      slowCnt_ff <= {CNT_W{1'b0}};
      blinkFast_ff <= 1'b0;
      blinkSlow_ff <= 1'b0;
    end else begin
      if (fastCnt_ff >= FAST_BLINK_CYC - cntOne) begin
        fastCnt_ff <= {CNT_W{1'b0}};
        blinkFast_ff <= ~blinkFast_ff;
      end else begin
        fastCnt_ff <= fastCnt_ff + cntOne;
      end
      if (slowCnt_ff >= SLOW_BLINK_CYC - cntOne) begin
        slowCnt_ff <= {CNT_W{1'b0}};
        blinkSlow_ff <= ~blinkSlow_ff;
      end else begin
        slowCnt_ff <= slowCnt_ff + cntOne;
      end
    end
  end

  ephy_led_drv #(
    .CNT_W(CNT_W),
    .NORMAL_CYC(NORMAL_STRETCH_CYC),
    .MEDIUM_CYC(MEDIUM_STRETCH_CYC),
    .LONG_CYC(LONG_STRETCH_CYC)
  ) uLedFirst (
    .ref_clk(ref_clk), .sys_rst(sys_rst),
    .selCode(phyLedControl_ff[`EPHY_LED_A_HI:`EPHY_LED_A_LO]),
    .stretchTimeSelect(phyLedControl_ff[`EPHY_STR_HI:`EPHY_STR_LO]),
    .pulseStretchEnable(phyLedControl_ff[`EPHY_STR_EN]),
    .txAct(txAct), .rxAct(rxAct), .colAct(colAct), .linkUp(linkUp), .fullDuplex(fullDuplex),
    .blinkFast(blinkFast_ff), .blinkSlow(blinkSlow_ff), .ledOut_ff(ledOutFirst)
  );

  ephy_led_drv #(
    .CNT_W(CNT_W),
    .NORMAL_CYC(NORMAL_STRETCH_CYC),
    .MEDIUM_CYC(MEDIUM_STRETCH_CYC),
    .LONG_CYC(LONG_STRETCH_CYC)
  ) uLedSecond (
    .ref_clk(ref_clk), .sys_rst(sys_rst),
    .selCode(phyLedControl_ff[`EPHY_LED_B_HI:`EPHY_LED_B_LO]),
    .stretchTimeSelect(phyLedControl_ff[`EPHY_STR_HI:`EPHY_STR_LO]),
    .pulseStretchEnable(phyLedControl_ff[`EPHY_STR_EN]),
    .txAct(txAct), .rxAct(rxAct), .colAct(colAct), .linkUp(linkUp), .fullDuplex(fullDuplex),
    .blinkFast(blinkFast_ff), .blinkSlow(blinkSlow_ff), .ledOut_ff(ledOutSecond)
  );
endmodule // ephy_status_led

`default_nettype wire

// *** bench/ephy_status_led_chk.sv ***
// Checker for the PHY status, LED and interrupt block.
// Sees only top ports; attached by the bind at the foot.
`timescale 1ns/1ps
`default_nettype none
module ephy_status_led_chk (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins
  input wire logic phySending,
  input wire logic ledOutFirst,
  input wire logic ledOutSecond,
  input wire logic masterModuleIrqFlag
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  logic [5:0] txHist_ff;
  wire done = psel && penable && pready;
  wire rdSt = done && !pwrite && paddr == 8'h00;
  wire rdEn = done && !pwrite && paddr == 8'h08;
  wire wrLed = done && pwrite && paddr == 8'h04;
  wire wrGlb = done && pwrite && paddr == 8'h18;
  always @(posedge ref_clk) begin
    txHist_ff <= {txHist_ff[4:0], phySending};
  end
  AST_RDY_AFTER_SETUP: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  AST_RDY_ONE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_ERR_WITH_RDY: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_RDATA_IDLE: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("prdata not zero outside answer");
  AST_ST_ZERO: assert property (rdSt |-> prdata[31:14] == 0 && prdata[9:0] == 0)
    else $error("status spare bits not zero");
  AST_COL: assert property (rdSt && prdata[11] |-> prdata[13] && prdata[12])
    else $error("collision without send and receive");
  AST_TX_BIT: assert property (rdSt && (&txHist_ff || !(|txHist_ff)) |-> prdata[13] == txHist_ff[0])
    else $error("send bit does not follow pin");
  AST_EN_ZERO: assert property (rdEn |-> prdata[31:7] == 0 && prdata[2] == 0)
    else $error("enable spare bits not zero");
  AST_LED_ON: assert property (wrLed && pwdata[11:8] == 4'h8 |=> ##[1:3] ledOutFirst)
    else $error("first led not on");
  AST_LED_OFF: assert property (wrLed && pwdata[7:4] inside {0, 6, 9, 14, 15} |=> ##[1:3] !ledOutSecond)
    else $error("second led not off");
  AST_GLB_OFF: assert property (wrGlb && !pwdata[0] |=> ##1 !masterModuleIrqFlag)
    else $error("master flag despite global disable");
  COV_STATUS: cover property (rdSt && prdata[11]);
  COV_LED: cover property (wrLed);
  COV_IRQ: cover property ($rose(masterModuleIrqFlag));
endmodule // ephy_status_led_chk
bind ephy_status_led ephy_status_led_chk u_chk (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .phySending(phySending), .ledOutFirst(ledOutFirst), .ledOutSecond(ledOutSecond),
  .masterModuleIrqFlag(masterModuleIrqFlag));
`default_nettype wire

// *** bench/ephy_led_mon.sv ***
// LED observer: counts lit cycles and turn-on events of one pin.
// Assumes the pin is sampled on ref_clk.
`timescale 1ns/1ps
`default_nettype none
module ephy_led_mon (
  // Clock and control
  input wire logic ref_clk,
  input wire logic clr,
  // LED pin
  input wire logic ledIn,
  // Measurements
  output logic [15:0] litCnt_ff,
  output logic [15:0] riseCnt_ff
);
  logic ledPrev_ff;
  always @(posedge ref_clk) begin
    ledPrev_ff <= ledIn;
    if (clr) begin
      litCnt_ff <= 16'h0000;
      riseCnt_ff <= 16'h0000;
    end else begin
      if (ledIn) litCnt_ff <= litCnt_ff + 16'h0001;
      if (ledIn && !ledPrev_ff) riseCnt_ff <= riseCnt_ff + 16'h0001;
    end
  end
endmodule // ephy_led_mon
`default_nettype wire

// *** bench/tb_top.sv ***
// Self-checking bench for the PHY status, LED and interrupt block.
// Short stretch and blink parameters keep the run brief.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, rdErr, monClr = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, rdData;
  logic phySending = 1'b0, phyReceiving = 1'b0, phyLinkUp = 1'b1, phyFullDuplex = 1'b1, rxPacketPending = 1'b0;
  logic [3:0] evtPulse = 4'h0;
  wire [31:0] prdata;
  wire pready, pslverr, ledOutFirst, ledOutSecond, masterModuleIrqFlag;
  wire [15:0] litCnt, riseCnt;
  int err_total = 0, check_count = 0;
  int bp[4] = '{0, 1, 3, 5};
  int strLo[5] = '{11, 19, 35, 3, 0};
  int strHi[5] = '{14, 22, 38, 5, 0};
  logic [2:0] strCfg[5] = '{3'h1, 3'h3, 3'h5, 3'h0, 3'h7};
  logic [3:0] stIn[4] = '{4'hD, 4'hE, 4'h4, 4'h9};
  logic [31:0] stExp[4] = '{32'h0000_3C00, 32'h0000_3000, 32'h0000_1000, 32'h0000_2400};
  logic [15:0] ledExp = 16'h11B2;
  always #2 ref_clk = ~ref_clk;
  ephy_status_led #(.NORMAL_STRETCH_CYC(24'h00_0008), .MEDIUM_STRETCH_CYC(24'h00_0010),
    .LONG_STRETCH_CYC(24'h00_0020), .FAST_BLINK_CYC(24'h00_0006), .SLOW_BLINK_CYC(24'h00_000C)) dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .phySending(phySending),
    .phyReceiving(phyReceiving), .phyLinkUp(phyLinkUp), .phyFullDuplex(phyFullDuplex),
    .rxPacketPending(rxPacketPending), .copyDone(evtPulse[3]), .sendDone(evtPulse[2]),
    .sendError(evtPulse[1]), .receiveError(evtPulse[0]), .ledOutFirst(ledOutFirst),
    .ledOutSecond(ledOutSecond), .masterModuleIrqFlag(masterModuleIrqFlag));
  ephy_led_mon mon (.ref_clk(ref_clk), .clr(monClr), .ledIn(ledOutFirst), .litCnt_ff(litCnt),
    .riseCnt_ff(riseCnt));
  task automatic finish_test();
    $display("Checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic chk_rng(input string nm, input int lo, input int hi, input logic [15:0] got);
    check_count++;
    if ($isunknown(got) || got < lo || got > hi) begin
      err_total++;
      $display("ERROR %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // One APB transfer; entered just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rdData = prdata;
    rdErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16) begin
      err_total++;
      finish_test();
    end
    @(posedge ref_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, exp, rdData);
  endtask
  initial begin
    #400000;
    err_total++;
    finish_test();
  end
  initial begin
    cyc(2);
    sys_rst <= 1'b0;
    monClr <= 1'b0;
    rd(8'h04, 32'h0000_3422, "led control reset");
    rd(8'h08, 32'h0000_0000, "irq enable reset");
    rd(8'h18, 32'h0000_0000, "global enable reset");
    wr(8'h08, 32'h0000_00FF);
    rd(8'h08, 32'h0000_007B, "irq enable bits");
    wr(8'h08, 32'h0000_0000);
    apb(1'b0, 8'h40, 32'h0000_0000);
    chk("unmapped error", 32'h0000_0001, rdErr);
    wr(8'h00, 32'hFFFF_FFFF);
    $display("register test done");
    for (int i = 0; i < 4; i++) begin
      {phySending, phyReceiving, phyFullDuplex, phyLinkUp} <= stIn[i];
      cyc(5);
      rd(8'h00, stExp[i], "status");
    end
    $display("status test done");
    {phySending, phyReceiving, phyFullDuplex, phyLinkUp} <= 4'hB;
    cyc(4);
    for (int c = 0; c < 16; c++) begin
      if (c == 10 || c == 11) continue;
      wr(8'h04, {16'h0000, 4'h3, c[3:0], c[3:0], 4'h0});
      cyc(6);
      chk("led first", ledExp[c], ledOutFirst);
      chk("led second", ledExp[c], ledOutSecond);
    end
    $display("led code test done");
    phySending <= 1'b0;
    cyc(4);
    for (int i = 0; i < 5; i++) begin
      wr(8'h04, {16'h0000, 8'h31, 4'h9, strCfg[i], 1'b0});
      monClr <= 1'b1;
      cyc(1);
      monClr <= 1'b0;
      phySending <= 1'b1;
      cyc(4);
      phySending <= 1'b0;
      cyc(60);
      chk_rng("stretch lit", strLo[i], strHi[i], litCnt);
    end
    for (int i = 0; i < 2; i++) begin
      wr(8'h04, {16'h0000, 4'h3, (i == 1) ? 4'hB : 4'hA, 8'h90});
      cyc(4);
      monClr <= 1'b1;
      cyc(1);
      monClr <= 1'b0;
      cyc(96);
      chk_rng("blink rises", (i == 1) ? 3 : 7, (i == 1) ? 5 : 9, riseCnt);
    end
    wr(8'h04, {16'h0000, 8'h3D, 8'h90});
    monClr <= 1'b1;
    cyc(1);
    monClr <= 1'b0;
    phySending <= 1'b1;
    cyc(4);
    phySending <= 1'b0;
    cyc(60);
    chk_rng("link activity lit", 50, 53, litCnt);
    $display("stretch and blink test done");
    wr(8'h18, 32'h0000_0001);
    for (int i = 0; i < 4; i++) begin
      evtPulse[i] <= 1'b1;
      cyc(1);
      evtPulse <= 4'h0;
      cyc(2);
      rd(8'h0C, 32'h0000_0001 << bp[i], "flag set");
      chk("master idle", 32'h0000_0000, masterModuleIrqFlag);
      wr(8'h08, 32'h0000_0001 << bp[i]);
      cyc(2);
      chk("master set", 32'h0000_0001, masterModuleIrqFlag);
      wr(8'h0C, 32'h0000_0001 << bp[i]);
      cyc(2);
      chk("master clear", 32'h0000_0000, masterModuleIrqFlag);
      rd(8'h0C, 32'h0000_0000, "flag clear");
      wr(8'h08, 32'h0000_0000);
    end
    wr(8'h0C, 32'h0000_002B);
    wr(8'h10, 32'h0000_0012);
    wr(8'h08, 32'h0000_0010);
    phyLinkUp <= 1'b0;
    cyc(8);
    chk("link master", 32'h0000_0001, masterModuleIrqFlag);
    rd(8'h0C, 32'h0000_0010, "link flag");
    rd(8'h14, 32'h0000_0014, "phy request");
    rd(8'h14, 32'h0000_0000, "phy request cleared");
    cyc(2);
    chk("link master clear", 32'h0000_0000, masterModuleIrqFlag);
    wr(8'h08, 32'h0000_0000);
    phyLinkUp <= 1'b1;
    cyc(8);
    chk("link disabled", 32'h0000_0000, masterModuleIrqFlag);
    rd(8'h14, 32'h0000_0014, "phy request again");
    wr(8'h08, 32'h0000_0040);
    rxPacketPending <= 1'b1;
    cyc(3);
    chk("pending master", 32'h0000_0001, masterModuleIrqFlag);
    wr(8'h18, 32'h0000_0000);
    cyc(2);
    chk("global off", 32'h0000_0000, masterModuleIrqFlag);
    rd(8'h0C, 32'h0000_0040, "pending flag");
    rxPacketPending <= 1'b0;
    $display("interrupt test done");
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
